// file: usb_irq_params.svh
// Command codes, field positions, reset values and timing for the irq block.
`ifndef USB_IRQ_PARAMS_SVH
`define USB_IRQ_PARAMS_SVH

// ----------------------------------------------------------------------
// Host-side command codes
// ----------------------------------------------------------------------
`define HC_STAT_RD    8'h03
`define HC_STAT_WR    8'h83
`define HC_GEN_EN_RD  8'h04
`define HC_GEN_EN_WR  8'h84
`define HC_CFG_RD     8'h20
`define HC_CFG_WR     8'hA0
`define HC_UPF_RD     8'h24
`define HC_UPF_WR     8'hA4
`define HC_UPE_RD     8'h25
`define HC_UPE_WR     8'hA5

// ----------------------------------------------------------------------
// Device-side command codes
// ----------------------------------------------------------------------
`define DC_MODE_RD    8'hB9
`define DC_MODE_WR    8'hB8
`define DC_CFG_RD     8'hBB
`define DC_CFG_WR     8'hBA
`define DC_FLAG_RD    8'hC0
`define DC_EN_RD      8'hC3
`define DC_EN_WR      8'hC2
`define DC_EPST_HI    4'h5

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define HCFG_PIN_EN   0
`define HCFG_EDGE     1
`define HCFG_POL      2
`define HC_MIE        31
`define HC_OPR        4
`define DMODE_GEN     3
`define DCFG_POL      0
`define DCFG_PULSE    1
`define DC_PSEUDO_FRAME_TICK       5
`define DC_BUSST      6

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define RST16         16'h0000
`define RST32         32'h0000_0000
`define CLK_NS        10
`define PULSE_NS      166
`define PULSE_CYC     ((`PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define FRAME_US      1000
`define FRAME_CYC     ((`FRAME_US * 1000) / `CLK_NS)
`define MISS_MAX      3

`endif

// file: usb_irq_pkg.sv
// Types shared by the USB host and device interrupt logic.
`default_nettype none
package usb_irq_pkg;

  // Device-side event strobes, one cycle each.
  typedef struct packed {
    logic [15:0] ep_done;
    logic        frame_start;
    logic        xfer_done;
    logic        short_done;
    logic        resume;
    logic        bus_reset;
  } dev_evt_t;

  // Which half of a 32-bit register the next data phase reaches.
  typedef enum logic {PH_LO, PH_HI} phase_t;

endpackage
`default_nettype wire

// file: usb_irq_ctrl.sv
// Interrupt request logic for the host and device halves of the controller.
//
// How it works
// - four pin modes, level-low after reset
// - host pin mode from config, pin enable bit
// - host event needs own enable and pin enable
// - general status only sets operational summary bit
// - six enabled general events ANDed with master
// - enabled processor events ORed into pin latch
// - pin enable low freezes host output level
// - device pin mode from config, global enable
// - device events logged, enabled ones request
// - device level low; pulse at least 166 ns (17 cycles, 170 ns) on rise
// - reading device flags clears low byte
// - endpoint flag clears on endpoint status read
// - bus status bit tracks live suspend state
// - endpoint events mean acknowledged transactions
// - pseudo frame tick every 1 ms without frame
// - three missed frames enter suspend
// - global enable low logs but no pin
// - enabling with pending bit asserts pin
// - disabling keeps pin until bits cleared
`timescale 1ns/1ps
`default_nettype none
`include "usb_irq_params.svh"

module usb_irq_ctrl
  import usb_irq_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = `FRAME_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        cs_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic [1:0]  addr,
  input  wire logic [15:0] data_in,
  output logic      [15:0] data_out,
  output logic             data_oe,
  input  wire logic [5:0]  host_gen_evt,
  input  wire logic [4:0]  host_cpu_evt,
  input  wire dev_evt_t    dev_evt,
  input  wire logic        bus_suspend_in,
  output logic             host_irq_out,
  output logic             dev_irq_out,
  output logic             dev_suspend_out
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Registers that take two data phases, low half first.
  function automatic logic is_wide(input logic [7:0] cmd);
    is_wide = (cmd == `HC_STAT_RD) || (cmd == `HC_STAT_WR) ||
              (cmd == `HC_GEN_EN_RD) || (cmd == `HC_GEN_EN_WR) ||
              (cmd == `DC_FLAG_RD);
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0]  hc_cmd_ff;
  logic [7:0]  dc_cmd_ff;
  phase_t      hc_ph_ff;
  phase_t      dc_ph_ff;
  logic [31:0] hc_stat_ff;
  logic [31:0] hc_gen_en_ff;
  logic [15:0] hc_cfg_ff;
  logic [15:0] hc_upf_ff;
  logic [15:0] hc_upe_ff;
  logic        hc_lat_ff;
  logic [7:0]  dc_mode_ff;
  logic [15:0] dc_cfg_ff;
  logic [23:0] dc_flag_ff;
  logic [23:0] dc_en_ff;
  logic        dreq_ff;
  logic [16:0] frm_cnt_ff;
  logic [1:0]  miss_ff;
  logic        susp_ff;
  logic [15:0] dout_ff;
  logic        doe_ff;

  // ----------------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------------
  wire rd_stb    = !cs_n && !rd_n && wr_n;
  wire wr_stb    = !cs_n && !wr_n;
  wire hc_cmd_wr = wr_stb && (addr == 2'b01);
  wire dc_cmd_wr = wr_stb && (addr == 2'b11);
  wire hc_dat_wr = wr_stb && (addr == 2'b00);
  wire hc_dat_rd = rd_stb && (addr == 2'b00);
  wire dc_dat_wr = wr_stb && (addr == 2'b10);
  wire dc_dat_rd = rd_stb && (addr == 2'b10);
  wire hc_hi     = (hc_ph_ff == PH_HI);
  wire dc_hi     = (dc_ph_ff == PH_HI);

  wire hc_acc = hc_dat_wr || hc_dat_rd;
  wire dc_acc = dc_dat_wr || dc_dat_rd;
  wire phase_t nxt_hc_ph = hc_cmd_wr ? PH_LO :
    (hc_acc && is_wide(hc_cmd_ff)) ? phase_t'(!hc_hi) : hc_ph_ff;
  wire phase_t nxt_dc_ph = dc_cmd_wr ? PH_LO :
    (dc_acc && is_wide(dc_cmd_ff)) ? phase_t'(!dc_hi) : dc_ph_ff;

  wire [31:0] wr_word = hc_hi ? {data_in, 16'h0000} : {16'h0000, data_in};
  wire [31:0] wr_mask = hc_hi ? 32'hFFFF_0000 : 32'h0000_FFFF;

  // ----------------------------------------------------------------------
  // Host side: general status group
  // ----------------------------------------------------------------------
  wire        stat_wr = hc_dat_wr && (hc_cmd_ff == `HC_STAT_WR);
  wire [31:0] stat_clr = stat_wr ? wr_word : `RST32;
  // Only the six event bits exist; set wins over a same-cycle clear.
  wire [31:0] nxt_hc_stat = {26'h0, (hc_stat_ff[5:0] & ~stat_clr[5:0]) |
                                    host_gen_evt};
  wire        gen_en_wr = hc_dat_wr && (hc_cmd_ff == `HC_GEN_EN_WR);
  wire [31:0] nxt_hc_gen_en = gen_en_wr ?
    ((hc_gen_en_ff & ~wr_mask) | wr_word) : hc_gen_en_ff;
  // General events reach the pin only through the summary bit and its processor enable.
  wire gen_hit = (|(hc_stat_ff[5:0] & hc_gen_en_ff[5:0])) &&
                 hc_gen_en_ff[`HC_MIE];

  // ----------------------------------------------------------------------
  // Host side: processor event group and pin latch
  // ----------------------------------------------------------------------
  wire [15:0] upf_set = {10'h0, host_cpu_evt[4], gen_hit,
                         host_cpu_evt[3:0]};
  wire        upf_wr  = hc_dat_wr && (hc_cmd_ff == `HC_UPF_WR);
  wire [15:0] upf_clr = upf_wr ? data_in : `RST16;
  wire [15:0] nxt_hc_upf = (hc_upf_ff & ~upf_clr) | upf_set;
  wire        upe_wr  = hc_dat_wr && (hc_cmd_ff == `HC_UPE_WR);
  wire [15:0] nxt_hc_upe = upe_wr ? data_in : hc_upe_ff;
  wire        cfg_wr  = hc_dat_wr && (hc_cmd_ff == `HC_CFG_WR);
  wire [15:0] nxt_hc_cfg = cfg_wr ? data_in : hc_cfg_ff;
  wire        host_or = |(hc_upf_ff & hc_upe_ff);
  // With the pin enable low the latch holds, so the pin cannot move even
  // while firmware rewrites flags and enables behind it.
  wire nxt_hc_lat = hc_cfg_ff[`HCFG_PIN_EN] ? host_or :
                    hc_lat_ff;

  // ----------------------------------------------------------------------
  // Device side: frame watchdog
  // ----------------------------------------------------------------------
  wire        frm_due = (frm_cnt_ff == 17'(FRAME_CYCLES - 1));
  wire        pseudo_frame_tick    = frm_due && !dev_evt.frame_start;
  wire [16:0] nxt_frm_cnt = (dev_evt.frame_start || frm_due) ? 17'h0_0000 :
                            frm_cnt_ff + 17'h0_0001;
  wire [1:0]  nxt_miss = dev_evt.frame_start ? 2'h0 :
    (pseudo_frame_tick && (miss_ff != 2'(`MISS_MAX))) ? miss_ff + 2'h1 : miss_ff;
  wire nxt_susp = dev_evt.frame_start ? 1'b0 :
                  (nxt_miss == 2'(`MISS_MAX));
  wire bus_state = bus_suspend_in || susp_ff;

  // ----------------------------------------------------------------------
  // Device side: flags and request
  // ----------------------------------------------------------------------
  // Acknowledged transactions arrive already qualified on dev_evt.ep_done.
  wire [23:0] dc_set = {dev_evt.ep_done, 2'b00, pseudo_frame_tick,
                        dev_evt.frame_start, dev_evt.xfer_done,
                        dev_evt.short_done, dev_evt.resume,
                        dev_evt.bus_reset};
  wire flag_rd = dc_dat_rd && !dc_hi && (dc_cmd_ff == `DC_FLAG_RD);
  wire ep_rd   = dc_dat_rd && (dc_cmd_ff[7:4] == `DC_EPST_HI);
  wire [23:0] ep_bit = 24'h00_0100 << dc_cmd_ff[3:0];
  wire [23:0] dc_clr = (flag_rd ? 24'h00_00FF : 24'h00_0000) |
                       (ep_rd ? ep_bit : 24'h00_0000);
  wire [23:0] nxt_dc_flag = (dc_flag_ff & ~dc_clr) | dc_set;
  wire        dc_en_wr = dc_dat_wr && (dc_cmd_ff == `DC_EN_WR);
  wire [23:0] nxt_dc_en = !dc_en_wr ? dc_en_ff :
    dc_hi ? {data_in[7:0], dc_en_ff[15:0]} : {dc_en_ff[23:16], data_in};
  wire        mode_wr = dc_dat_wr && (dc_cmd_ff == `DC_MODE_WR);
  wire [7:0]  nxt_dc_mode = mode_wr ? data_in[7:0] : dc_mode_ff;
  wire        dcfg_wr = dc_dat_wr && (dc_cmd_ff == `DC_CFG_WR);
  wire [15:0] nxt_dc_cfg = dcfg_wr ? data_in : dc_cfg_ff;
  wire        dev_pend = |(dc_flag_ff & dc_en_ff);
  // Request rises only with the global enable, but once up it falls only
  // when the pending bits are gone; that is why clearing the global enable
  // alone never releases the pin.
  wire nxt_dreq = dev_pend &&
    (dc_mode_ff[`DMODE_GEN] || dreq_ff);

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  wire [23:0] dc_view = dc_flag_ff | ({23'h0, bus_state} << `DC_BUSST);
  logic [15:0] hc_rdata;
  logic [15:0] dc_rdata;

  always_comb begin
    hc_rdata = `RST16;
    unique case (hc_cmd_ff)
      `HC_STAT_RD:   hc_rdata = hc_hi ? hc_stat_ff[31:16] : hc_stat_ff[15:0];
      `HC_GEN_EN_RD: hc_rdata = hc_hi ? hc_gen_en_ff[31:16] :
                                        hc_gen_en_ff[15:0];
      `HC_CFG_RD:    hc_rdata = hc_cfg_ff;
      `HC_UPF_RD:    hc_rdata = hc_upf_ff;
      `HC_UPE_RD:    hc_rdata = hc_upe_ff;
      default:       hc_rdata = `RST16;
    endcase
  end

  always_comb begin
    dc_rdata = `RST16;
    unique case (dc_cmd_ff)
      `DC_MODE_RD: dc_rdata = {8'h00, dc_mode_ff};
      `DC_CFG_RD:  dc_rdata = dc_cfg_ff;
      `DC_FLAG_RD: dc_rdata = dc_hi ? {8'h00, dc_view[23:16]} :
                                      dc_view[15:0];
      `DC_EN_RD:   dc_rdata = dc_hi ? {8'h00, dc_en_ff[23:16]} :
                                      dc_en_ff[15:0];
      default:     dc_rdata = (dc_cmd_ff[7:4] == `DC_EPST_HI) ?
                     {15'h0000, |(dc_flag_ff & ep_bit)} : `RST16;
    endcase
  end

  // ----------------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      hc_cmd_ff    <= 8'h00;
      dc_cmd_ff    <= 8'h00;
      hc_ph_ff     <= PH_LO;
      dc_ph_ff     <= PH_LO;
      hc_stat_ff   <= `RST32;
      hc_gen_en_ff <= `RST32;
      hc_cfg_ff    <= `RST16;
      hc_upf_ff    <= `RST16;
      hc_upe_ff    <= `RST16;
      hc_lat_ff    <= 1'b0;
      dc_mode_ff   <= 8'h00;
      dc_cfg_ff    <= `RST16;
      dc_flag_ff   <= 24'h00_0000;
      dc_en_ff     <= 24'h00_0000;
      dreq_ff      <= 1'b0;
      frm_cnt_ff   <= 17'h0_0000;
      miss_ff      <= 2'h0;
      susp_ff      <= 1'b0;
      dout_ff      <= `RST16;
      doe_ff       <= 1'b0;
    end else begin
      hc_cmd_ff    <= hc_cmd_wr ? data_in[7:0] : hc_cmd_ff;
      dc_cmd_ff    <= dc_cmd_wr ? data_in[7:0] : dc_cmd_ff;
      hc_ph_ff     <= nxt_hc_ph;
      dc_ph_ff     <= nxt_dc_ph;
      hc_stat_ff   <= nxt_hc_stat;
      hc_gen_en_ff <= nxt_hc_gen_en;
      hc_cfg_ff    <= nxt_hc_cfg;
      hc_upf_ff    <= nxt_hc_upf;
      hc_upe_ff    <= nxt_hc_upe;
      hc_lat_ff    <= nxt_hc_lat;
      dc_mode_ff   <= nxt_dc_mode;
      dc_cfg_ff    <= nxt_dc_cfg;
      dc_flag_ff   <= nxt_dc_flag;
      dc_en_ff     <= nxt_dc_en;
      dreq_ff      <= nxt_dreq;
      frm_cnt_ff   <= nxt_frm_cnt;
      miss_ff      <= nxt_miss;
      susp_ff      <= nxt_susp;
      dout_ff      <= hc_dat_rd ? hc_rdata : dc_rdata;
      doe_ff       <= hc_dat_rd || dc_dat_rd;
    end
  end

  // ----------------------------------------------------------------------
  // Pin shaping, one stage per request output
  // ----------------------------------------------------------------------
  // Index 0 is the host pin, 1 the device pin. Both share the pulse width
  // so firmware sees the same edge timing whichever half interrupts.
  wire [1:0] src  = {dreq_ff, hc_lat_ff};
  wire [1:0] edg  = {dc_cfg_ff[`DCFG_PULSE], hc_cfg_ff[`HCFG_EDGE]};
  wire [1:0] pol  = {dc_cfg_ff[`DCFG_POL], hc_cfg_ff[`HCFG_POL]};
  logic [1:0] pin_ff;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
      logic       prev_ff;
      logic [4:0] cnt_ff;
      wire        rise    = src[gi] && !prev_ff;
      wire [4:0]  nxt_cnt = rise ? 5'(`PULSE_CYC) :
                            (cnt_ff != 5'h00) ? cnt_ff - 5'h01 : 5'h00;
      wire        active  = edg[gi] ? (nxt_cnt != 5'h00) : src[gi];
      wire        nxt_pin = pol[gi] ? active : !active;

      always_ff @(posedge sys_clk) begin
        if (!rstn) begin
          prev_ff    <= 1'b0;
          cnt_ff     <= 5'h00;
          pin_ff[gi] <= 1'b1;
        end else begin
          prev_ff    <= src[gi];
          cnt_ff     <= nxt_cnt;
          pin_ff[gi] <= nxt_pin;
        end
      end
    end
  endgenerate

  assign host_irq_out    = pin_ff[0];
  assign dev_irq_out     = pin_ff[1];
  assign dev_suspend_out = susp_ff;
  assign data_out        = dout_ff;
  assign data_oe         = doe_ff;

endmodule
`default_nettype wire

// file: usb_irq_chk.sv
// Concurrent checks on the ports of the interrupt block, bound to its top.
`timescale 1ns/1ps
`default_nettype none
module usb_irq_chk
  import usb_irq_pkg::*;
#(
  parameter int unsigned FRAME_CYCLES = 50
) (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic [1:0]  addr,
  input wire logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic        data_oe,
  input wire logic [5:0]  host_gen_evt,
  input wire logic [4:0]  host_cpu_evt,
  input wire dev_evt_t    dev_evt,
  input wire logic        bus_suspend_in,
  input wire logic        host_irq_out,
  input wire logic        dev_irq_out,
  input wire logic        dev_suspend_out
);
  logic        rd_s;
  logic        h_wr;
  logic        h_act;
  logic        h_tch_ff;
  logic        d_tch_ff;
  logic [4:0]  h_idle_ff;
  logic [31:0] since_ff;
  assign rd_s  = !cs_n && !rd_n && wr_n && !addr[0];
  assign h_wr  = !cs_n && !wr_n && !addr[1];
  assign h_act = h_wr || (|host_gen_evt) || (|host_cpu_evt);
  // The idle counter saturates so a long quiet spell never wraps to zero.
  always_ff @(posedge sys_clk) begin
    h_tch_ff  <= rstn && (h_tch_ff || h_wr);
    d_tch_ff  <= rstn && (d_tch_ff || (!cs_n && !wr_n && addr[1]));
    h_idle_ff <= (!rstn || h_act) ? 5'h00
               : h_idle_ff + 5'(h_idle_ff != 5'h1F);
    since_ff  <= (!rstn || dev_evt.frame_start) ? 32'h0 : since_ff + 32'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_reset_idle: assert property (
    $rose(rstn) |-> host_irq_out && dev_irq_out && !dev_suspend_out
    && !data_oe) else $error("Outputs not idle after reset.");
  a_read_answer: assert property (
    rd_s |=> data_oe) else $error("Read got no answer.");
  a_oe_cause: assert property (
    data_oe |-> $past(rd_s)) else $error("Data enable without a read.");
  a_host_untouched: assert property (
    !h_tch_ff |-> host_irq_out) else $error("Host pin active unprogrammed.");
  a_dev_untouched: assert property (
    !d_tch_ff |-> dev_irq_out) else $error("Device pin active unprogrammed.");
  a_host_change_cause: assert property (
    $changed(host_irq_out) |-> h_idle_ff <= 5'd24)
    else $error("Host pin moved without a cause.");
  a_suspend_clear: assert property (
    dev_evt.frame_start |=> !dev_suspend_out)
    else $error("Suspend kept after frame start.");
  a_suspend_when: assert property (
    $rose(dev_suspend_out) |-> since_ff >= 3 * FRAME_CYCLES - 3
    && since_ff <= 3 * FRAME_CYCLES + 3) else $error("Suspend off time.");
endmodule
bind usb_irq_ctrl usb_irq_chk #(.FRAME_CYCLES(FRAME_CYCLES)) chk_i (
  .sys_clk(sys_clk), .rstn(rstn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
  .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
  .host_gen_evt(host_gen_evt), .host_cpu_evt(host_cpu_evt),
  .dev_evt(dev_evt), .bus_suspend_in(bus_suspend_in),
  .host_irq_out(host_irq_out), .dev_irq_out(dev_irq_out),
  .dev_suspend_out(dev_suspend_out));
`default_nettype wire

// file: usb_cpu_model.sv
// Processor model making command and data accesses on the pin bus.
`timescale 1ns/1ps
`default_nettype none
module usb_cpu_model (
  input  wire logic        sys_clk,
  output logic             cs_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic      [1:0]  addr,
  output logic      [15:0] data_in,
  input  wire logic [15:0] data_out,
  input  wire logic        data_oe
);
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 2'h0;
    data_in = 16'h0000;
  end
  // Data lines are inverted on release so stale values never look valid.
  task automatic acc(input logic [1:0] a, input logic w,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge sys_clk);
    cs_n <= 1'b0;
    rd_n <= w;
    wr_n <= !w;
    addr <= a;
    data_in <= d;
    @(posedge sys_clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    data_in <= ~d;
    #1;
    q = data_oe ? data_out : 'x;
  endtask
  task automatic reg_acc(input logic s, input logic w, input logic [7:0] code,
                         input int n, input logic [31:0] v,
                         output logic [31:0] q);
    logic [15:0] r;
    q = 32'h0;
    acc({s, 1'b1}, 1'b1, {8'h00, code}, r);
    acc({s, 1'b0}, w, v[15:0], r);
    q[15:0] = r;
    if (n == 2) begin
      acc({s, 1'b0}, w, v[31:16], r);
      q[31:16] = r;
    end
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking testbench for the host and device interrupt logic.
`timescale 1ns/1ps
`default_nettype none
`include "usb_irq_params.svh"
module testbench
  import usb_irq_pkg::*;
;
  logic        sys_clk, rstn, cs_n, rd_n, wr_n, data_oe, bus_suspend_in;
  logic        host_irq_out, dev_irq_out, dev_suspend_out;
  logic [1:0]  addr;
  logic [15:0] data_in, data_out;
  logic [5:0]  host_gen_evt;
  logic [4:0]  host_cpu_evt;
  dev_evt_t    dev_evt;
  int          fail_count = 0;
  int          checks = 0;
  int          seed = 77;
  int          cyc = 0;
  always #5 sys_clk = ~sys_clk;
  usb_irq_ctrl #(.FRAME_CYCLES(50)) uut (.sys_clk(sys_clk), .rstn(rstn),
    .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .host_gen_evt(host_gen_evt),
    .host_cpu_evt(host_cpu_evt), .dev_evt(dev_evt),
    .bus_suspend_in(bus_suspend_in), .host_irq_out(host_irq_out),
    .dev_irq_out(dev_irq_out), .dev_suspend_out(dev_suspend_out));
  usb_cpu_model cpu (.sys_clk(sys_clk), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe));
  task automatic end_sim();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic pin(input logic s);
    return s ? dev_irq_out : host_irq_out;
  endfunction
  task automatic rw(input logic s, input logic [7:0] c, input logic [31:0] v);
    logic [31:0] q;
    cpu.reg_acc(s, 1'b1, c, 1, v, q);
  endtask
  task automatic rd(input logic s, input logic [7:0] c, output logic [31:0] q);
    cpu.reg_acc(s, 1'b0, c, 2, 32'h0, q);
  endtask
  task automatic pulse(input logic [5:0] g, input logic [4:0] h,
                       input dev_evt_t d);
    @(posedge sys_clk);
    host_gen_evt <= g;
    host_cpu_evt <= h;
    dev_evt <= d;
    @(posedge sys_clk);
    host_gen_evt <= 6'h00;
    host_cpu_evt <= 5'h00;
    dev_evt <= '0;
  endtask
  // ----------------------------------------------------------------------
  // One pin mode: masked event, enable, active count, clear
  // ----------------------------------------------------------------------
  task automatic mode_test(input logic s, input logic [1:0] m);
    logic [31:0] q;
    int          k, c, fb;
    k = $unsigned($random(seed)) % 5;
    fb = k < 4 ? k : 5;
    rw(s, s ? 8'hBA : 8'hA0, s ? {30'h0, m} : {29'h0, m[0], m[1], 1'b1});
    rw(s, s ? 8'hC2 : 8'hA5, 32'h0);
    pulse(6'h00, s ? 5'h00 : 5'(1 << k), s ? 21'h1 : 21'h0);
    wt(6);
    chk(pin(s), !m[0]);
    rw(s, s ? 8'hC2 : 8'hA5, s ? 32'h1 : 32'h1 << fb);
    c = 0;
    repeat (30) begin
      wt(1);
      c += (pin(s) === m[0]);
    end
    chk(m[1] ? c : (c > 25), m[1] ? `PULSE_CYC : 1);
    if (s) rd(1'b1, 8'hC0, q);
    else rw(1'b0, 8'hA4, 32'h1 << fb);
    wt(6);
    chk(pin(s), !m[0]);
  endtask
  initial begin
    logic [31:0] q;
    int          i, e;
    sys_clk = 1'b0;
    rstn = 1'b0;
    host_gen_evt = 6'h00;
    host_cpu_evt = 5'h00;
    dev_evt = '0;
    bus_suspend_in = 1'b0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    wt(1);
    chk({host_irq_out, dev_irq_out}, 2'b11);
    rd(1'b0, 8'h20, q);
    chk(q[15:0], 16'h0000);
    rd(1'b1, 8'hBB, q);
    chk(q[15:0], 16'h0000);
    $display("reset test done");
    for (i = 0; i < 4; i++) mode_test(1'b0, i[1:0]);
    // Mask by enables, then pin enable off; the pending flag must survive.
    rw(1'b0, 8'hA0, 32'h1);
    rw(1'b0, 8'hA5, 32'h1);
    pulse(6'h00, 5'h01, '0);
    wt(6);
    chk(host_irq_out, 1'b0);
    rw(1'b0, 8'hA5, 32'h0);
    rw(1'b0, 8'hA0, 32'h0);
    wt(6);
    chk(host_irq_out, 1'b1);
    rw(1'b0, 8'hA5, 32'h1);
    wt(6);
    chk(host_irq_out, 1'b1);
    rw(1'b0, 8'hA0, 32'h1);
    wt(6);
    chk(host_irq_out, 1'b0);
    // Disable by clearing flags first; a new event must not move the pin.
    rd(1'b0, 8'h20, q);
    chk(q[0], 1'b1);
    rw(1'b0, 8'hA4, 32'hFFFF);
    rw(1'b0, 8'hA0, 32'h0);
    wt(6);
    chk(host_irq_out, 1'b1);
    pulse(6'h00, 5'h01, '0);
    wt(6);
    chk(host_irq_out, 1'b1);
    rw(1'b0, 8'hA0, 32'h1);
    wt(6);
    chk(host_irq_out, 1'b0);
    rw(1'b0, 8'hA4, 32'h1);
    wt(6);
    chk(host_irq_out, 1'b1);
    i = $unsigned($random(seed)) % 6;
    cpu.reg_acc(1'b0, 1'b1, 8'h84, 2, (32'h1 << i) | 32'h8000_0000, q);
    pulse(6'(1 << i), 5'h00, '0);
    wt(6);
    chk(host_irq_out, 1'b1);
    rd(1'b0, 8'h24, q);
    chk(q[4], 1'b1);
    rw(1'b0, 8'hA5, 32'h10);
    wt(6);
    chk(host_irq_out, 1'b0);
    cpu.reg_acc(1'b0, 1'b1, 8'h83, 2, 32'h1 << i, q);
    rw(1'b0, 8'hA4, 32'h10);
    wt(6);
    chk(host_irq_out, 1'b1);
    cpu.reg_acc(1'b0, 1'b1, 8'h84, 2, 32'h1 << i, q);
    pulse(6'(1 << i), 5'h00, '0);
    wt(6);
    rd(1'b0, 8'h24, q);
    chk(q[4], 1'b0);
    $display("host test done");
    rw(1'b1, 8'hB8, 32'h8);
    for (i = 0; i < 4; i++) mode_test(1'b1, i[1:0]);
    rw(1'b1, 8'hBA, 32'h0);
    rw(1'b1, 8'hB8, 32'h0);
    rw(1'b1, 8'hC2, 32'h1);
    pulse(6'h00, 5'h00, 21'h1);
    wt(6);
    chk(dev_irq_out, 1'b1);
    rw(1'b1, 8'hB8, 32'h8);
    wt(6);
    chk(dev_irq_out, 1'b0);
    rw(1'b1, 8'hB8, 32'h0);
    wt(6);
    chk(dev_irq_out, 1'b0);
    rw(1'b1, 8'hB8, 32'h8);
    rd(1'b1, 8'hC0, q);
    chk(q[0], 1'b1);
    wt(6);
    chk(dev_irq_out, 1'b1);
    rd(1'b1, 8'hC0, q);
    chk(q[0], 1'b0);
    e = $unsigned($random(seed)) % 8;
    rw(1'b1, 8'hC2, 32'h100 << e);
    pulse(6'h00, 5'h00, 21'(21'h20 << e));
    wt(6);
    chk(dev_irq_out, 1'b0);
    rd(1'b1, 8'hC0, q);
    chk(q[8 + e], 1'b1);
    wt(6);
    chk(dev_irq_out, 1'b0);
    rd(1'b1, 8'(8'h50 + e), q);
    chk(q[15:0], 16'h0001);
    wt(6);
    chk(dev_irq_out, 1'b1);
    // A frame start first, so the missed-frame suspend does not hold the bus status bit.
    pulse(6'h00, 5'h00, 21'h10);
    bus_suspend_in <= 1'b1;
    rd(1'b1, 8'hC0, q);
    chk(q[6], 1'b1);
    bus_suspend_in <= 1'b0;
    rd(1'b1, 8'hC0, q);
    chk(q[6], 1'b0);
    pulse(6'h00, 5'h00, 21'h10);
    rd(1'b1, 8'hC0, q);
    wt(60);
    rd(1'b1, 8'hC0, q);
    chk(q[5], 1'b1);
    wt(120);
    chk(dev_suspend_out, 1'b1);
    pulse(6'h00, 5'h00, 21'h10);
    wt(2);
    chk(dev_suspend_out, 1'b0);
    $display("device test done");
    end_sim();
  end
endmodule
`default_nettype wire
